// ---- rtl/tmr8_timer.sv ----
// 8-bit timer, shared 10-bit prescaler, external count pin and CPU registers
`timescale 1ns/1ns
module tmr8_timer #(
  parameter int CNT_W = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic external_count_pin_i,
  input wire logic wide_timer_count_pin_i,
  input wire logic global_irq_enable_i,
  input wire logic ovf_vector_ack_i,
  output logic ovf_irq_o,
  output logic wide_tick_o
);
  // Only the 8-bit counter width is served
  if (CNT_W != 8) begin : g_bad_cnt_w
    $error("tmr8_timer supports an 8-bit counter only");
  end

  // Channel 0 feeds this timer, channel 1 the wide timer
  localparam int N_CH = 2;
  localparam int CH_OWN = 0;
  localparam int CH_WIDE = 1;

  // Register address match, used by every write decoder
  function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] target);
    reg_hit = addr == target;
  endfunction

  // Tick from a select code, shared by both timers
  function automatic logic tick_of(input logic [2:0] sel, input logic [9:0] psc,
                                   input logic rise, input logic fall);
    case (sel)
      tmr8_pkg::SEL_STOP: begin
        tick_of = 1'b0;
      end
      tmr8_pkg::SEL_CLK: begin
        tick_of = 1'b1;
      end
      tmr8_pkg::SEL_DIV8: begin
        tick_of = &psc[2:0];
      end
      tmr8_pkg::SEL_DIV64: begin
        tick_of = &psc[5:0];
      end
      tmr8_pkg::SEL_DIV256: begin
        tick_of = &psc[7:0];
      end
      tmr8_pkg::SEL_DIV1024: begin
        tick_of = &psc[9:0];
      end
      tmr8_pkg::SEL_FALL: begin
        tick_of = fall;
      end
      tmr8_pkg::SEL_RISE: begin
        tick_of = rise;
      end
      default: begin
        tick_of = 1'b0;
      end
    endcase
  endfunction

  // Read word for one address; unmapped and write-only bits give zero
  function automatic logic [7:0] read_word(input logic [2:0] addr,
                                           input logic [2:0] sel,
                                           input logic [7:0] count,
                                           input logic ovf_en,
                                           input logic ovf_flag,
                                           input logic [2:0] wide_sel);
    case (addr)
      tmr8_pkg::ADDR_CONTROL: begin
        read_word = {5'h00, sel};
      end
      tmr8_pkg::ADDR_COUNT: begin
        read_word = count;
      end
      tmr8_pkg::ADDR_MASK: begin
        read_word = {7'h00, ovf_en};
      end
      tmr8_pkg::ADDR_FLAGS: begin
        read_word = {7'h00, ovf_flag};
      end
      tmr8_pkg::ADDR_SFIO: begin
        read_word = 8'h00;
      end
      tmr8_pkg::ADDR_WIDE_SEL: begin
        read_word = {5'h00, wide_sel};
      end
      default: begin
        read_word = 8'h00;
      end
    endcase
  endfunction

  logic [2:0] sel_r;
  logic [2:0] wide_sel_r;
  logic [7:0] count_r;
  logic ovf_en_r;
  logic ovf_flag_r;
  logic [9:0] psc_r;
  logic [N_CH-1:0] pin_in;
  logic [N_CH-1:0] pin_rise;
  logic [N_CH-1:0] pin_fall;
  logic timer_tick;
  logic wide_tick_nxt;
  logic wr_control;
  logic wr_count;
  logic wr_mask;
  logic wr_flags;
  logic wr_sfio;
  logic wr_wide_sel;
  logic psc_clear;
  logic count_at_max;
  logic ovf_event;
  logic flag_clear_sw;

  // Write decoders
  assign wr_control = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_CONTROL);
  assign wr_count = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_COUNT);
  assign wr_mask = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_MASK);
  assign wr_flags = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_FLAGS);
  assign wr_sfio = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_SFIO);
  assign wr_wide_sel = wr_i && reg_hit(addr_i, tmr8_pkg::ADDR_WIDE_SEL);

  // Reset bit is a strobe only, never stored
  assign psc_clear = wr_sfio && wdata_i[tmr8_pkg::PSC_RESET_BIT];

  // Free-running prescaler shared with the wide timer
  always_ff @(posedge mclk_i) begin
    if (srst_i || psc_clear) begin
      psc_r <= '0;
    end else begin
      psc_r <= psc_r + 10'h001;
    end
  end

  // Pin levels into the sampling channels
  assign pin_in[CH_OWN] = external_count_pin_i;
  assign pin_in[CH_WIDE] = wide_timer_count_pin_i;

  // Two-stage sampling stands in for latch plus register
  for (genvar ch = 0; ch < N_CH; ch++) begin : g_pin_sync
    logic smp_a_r;
    logic smp_b_r;
    logic smp_d_r;

    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        smp_a_r <= 1'b0;
        smp_b_r <= 1'b0;
        smp_d_r <= 1'b0;
      end else begin
        smp_a_r <= pin_in[ch];
        smp_b_r <= smp_a_r;
        smp_d_r <= smp_b_r;
      end
    end

    // One pulse per sampled edge
    assign pin_rise[ch] = smp_b_r & ~smp_d_r;
    assign pin_fall[ch] = ~smp_b_r & smp_d_r;
  end

  // Edge pulses bypass the prescaler
  assign timer_tick = tick_of(sel_r, psc_r, pin_rise[CH_OWN],
                              pin_fall[CH_OWN]);
  assign wide_tick_nxt = tick_of(wide_sel_r, psc_r, pin_rise[CH_WIDE],
                                 pin_fall[CH_WIDE]);

  // Clock select of this timer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sel_r <= tmr8_pkg::SEL_STOP;
    end else if (wr_control) begin
      sel_r <= wdata_i[tmr8_pkg::SEL_LSB +: tmr8_pkg::SEL_W];
    end
  end

  // Separate clock select of the wide timer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wide_sel_r <= tmr8_pkg::SEL_STOP;
    end else if (wr_wide_sel) begin
      wide_sel_r <= wdata_i[tmr8_pkg::SEL_LSB +: tmr8_pkg::SEL_W];
    end
  end

  // Overflow interrupt enable
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ovf_en_r <= 1'b0;
    end else if (wr_mask) begin
      ovf_en_r <= wdata_i[tmr8_pkg::OVF_ENABLE_BIT];
    end
  end

  // Counter; tick is an enable only
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_r <= tmr8_pkg::RESET_BYTE;
    end else if (wr_count) begin
      count_r <= wdata_i;
    end else if (timer_tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // Overflow only from a tick that the counter actually takes
  assign count_at_max = count_r == tmr8_pkg::COUNT_MAX;
  assign ovf_event = timer_tick && !wr_count && count_at_max;
  assign flag_clear_sw = wr_flags && wdata_i[tmr8_pkg::OVF_FLAG_BIT];

  // Set beats both clears
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_event) begin
      ovf_flag_r <= 1'b1;
    end else if (ovf_vector_ack_i) begin
      ovf_flag_r <= 1'b0;
    end else if (flag_clear_sw) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // Overflow request, one cycle behind its terms
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ovf_irq_o <= 1'b0;
    end else begin
      ovf_irq_o <= ovf_en_r & global_irq_enable_i & ovf_flag_r;
    end
  end

  // Registered tick for the wide timer
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wide_tick_o <= 1'b0;
    end else begin
      wide_tick_o <= wide_tick_nxt;
    end
  end

  // Read data stand for the one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= read_word(addr_i, sel_r, count_r, ovf_en_r, ovf_flag_r,
                           wide_sel_r);
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Prescaler width fixed by the register map
  if (tmr8_pkg::PSC_W != 10) begin : g_bad_psc_w
    $error("tmr8_timer needs a 10-bit prescaler");
  end
endmodule

// ---- rtl/tmr8_pkg.sv ----
// Constants for the 8-bit timer with shared prescaler
package tmr8_pkg;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_MASK = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_SFIO = 3'h4;
  localparam logic [2:0] ADDR_WIDE_SEL = 3'h5;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int OVF_ENABLE_BIT = 0;
  localparam int OVF_FLAG_BIT = 0;
  localparam int PSC_RESET_BIT = 0;
  localparam int PSC_W = 10;
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_CLK = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_DIV256 = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam logic [2:0] SEL_FALL = 3'h6;
  localparam logic [2:0] SEL_RISE = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage

// ---- verification/tmr8_assertions.sv ----
// Port assertions for the 8-bit timer
`timescale 1ns/1ns
module tmr8_assertions (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic ovf_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence wr_rd(a);
    wr_i && addr_i == a ##1 rd_i && addr_i == a;
  endsequence
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("idle read data");
  AST_CNT_RW: assert property (wr_rd(3'h1) |=> rdata_o == $past(wdata_i, 2))
    else $error("count readback");
  AST_MASK_RW: assert property (wr_rd(3'h2) |=> rdata_o[0] == $past(wdata_i[0], 2))
    else $error("mask readback");
  AST_SEL_RW: assert property (wr_rd(3'h0) |=> rdata_o[2:0] == $past(wdata_i[2:0], 2))
    else $error("select readback");
  AST_PSC_RD: assert property (rd_i && addr_i == 3'h4 |=> !rdata_o[0])
    else $error("reset bit read");
  AST_UNMAPPED: assert property (rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00)
    else $error("unmapped read");
  AST_IRQ_OFF: assert property (!global_irq_enable_i |=> !ovf_irq_o)
    else $error("irq while masked");
  AST_IRQ_RISE: assert property ($rose(ovf_irq_o) |-> $past(global_irq_enable_i))
    else $error("irq rise");
endmodule
bind tmr8_timer tmr8_assertions chk (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .global_irq_enable_i, .ovf_irq_o);

// ---- verification/tmr8_pin_model.sv ----
// Far-side source of the external count pin
`timescale 1ns/1ns
module tmr8_pin_model (
  input wire logic mclk_i,
  input wire logic en_i,
  output logic pin_o
);
  logic ph_r = 1'b0;
  initial pin_o = 1'b0;
  // Each level held two cycles
  always @(posedge mclk_i) begin
    if (en_i) begin
      ph_r <= ~ph_r;
      if (ph_r) pin_o <= ~pin_o;
    end
  end
endmodule

// ---- verification/tmr8_timer_tb_top.sv ----
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ns
module tmr8_timer_tb_top;
  logic mclk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, gie = 1'b0, ack = 1'b0;
  logic wpin = 1'b0, en = 1'b0, rd_d = 1'b0, pin, irq, wtick;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [7:0] q[$];
  int seed = 32'h7679, fails = 0, n_checks = 0, i, k;
  always #50 mclk_i = ~mclk_i;
  tmr8_timer DUT (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .external_count_pin_i(pin), .wide_timer_count_pin_i(wpin), .global_irq_enable_i(gie),
    .ovf_vector_ack_i(ack), .ovf_irq_o(irq), .wide_tick_o(wtick));
  tmr8_pin_model PM (.mclk_i, .en_i(en), .pin_o(pin));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    if (!w) q.push_back(d);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_irq;
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge mclk_i);
    if (k == 300) begin
      fails++;
      give_verdict();
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (rd_d) cmp(rdata_o, q.pop_front());
    rd_d <= rd_i;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 8; i++) bus(1'b0, i[2:0], 8'h00);
    repeat (3) begin
      i = $random(seed);
      bus(1'b1, 3'h1, i[7:0]);
      bus(1'b0, 3'h1, i[7:0]);
    end
    for (i = 7; i >= 0; i--) begin
      wpin <= 1'($random(seed));
      bus(1'b1, 3'h5, 8'(7 - i));
      bus(1'b1, 3'h0, 8'(i));
      bus(1'b0, 3'h0, 8'(i));
      bus(1'b0, 3'h5, 8'(7 - i));
    end
    wpin <= 1'b0;
    bus(1'b1, 3'h5, 8'h01);
    idle(3);
    cmp({7'h00, wtick}, 8'h01);
    bus(1'b1, 3'h5, 8'h00);
    idle(3);
    cmp({7'h00, wtick}, 8'h00);
    gie <= 1'b1;
    bus(1'b1, 3'h2, 8'h01);
    bus(1'b0, 3'h2, 8'h01);
    bus(1'b1, 3'h1, 8'hfe);
    bus(1'b1, 3'h0, 8'h01);
    idle(1);
    wait_irq();
    bus(1'b1, 3'h0, 8'h00);
    bus(1'b1, 3'h3, 8'h00);
    bus(1'b0, 3'h3, 8'h01);
    bus(1'b1, 3'h3, 8'h01);
    bus(1'b0, 3'h3, 8'h00);
    bus(1'b1, 3'h1, 8'hff);
    bus(1'b1, 3'h0, 8'h01);
    idle(1);
    wait_irq();
    ack <= 1'b1;
    bus(1'b1, 3'h0, 8'h00);
    ack <= 1'b0;
    bus(1'b0, 3'h3, 8'h00);
    idle(2);
    cmp({7'h00, irq}, 8'h00);
    bus(1'b1, 3'h1, 8'h00);
    bus(1'b1, 3'h4, 8'h01);
    bus(1'b1, 3'h0, 8'h02);
    idle(7);
    bus(1'b0, 3'h1, 8'h01);
    bus(1'b0, 3'h4, 8'h00);
    bus(1'b1, 3'h0, 8'h00);
    for (i = 7; i >= 6; i--) begin
      bus(1'b1, 3'h1, 8'h00);
      bus(1'b1, 3'h0, 8'(i));
      idle(2);
      en <= 1'b1;
      idle(40);
      en <= 1'b0;
      idle(6);
      bus(1'b0, 3'h1, 8'h0a);
    end
    idle(3);
    give_verdict();
  end
endmodule
